//--- include/tmo_pkg.sv
// constants for the contact uart timeout counter block
package tmo_pkg;
  localparam logic [7:0] OFS_RELOAD_LOW = 8'h00;
  localparam logic [7:0] OFS_RELOAD_MID = 8'h04;
  localparam logic [7:0] OFS_RELOAD_HIGH = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_STATUS2 = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_FIFO_FILL = 8'h5c;
  localparam logic [7:0] OFS_MIXED = 8'h60;
  localparam logic [7:0] CFG_STOP = 8'h00;
  localparam logic [7:0] CFG_SINGLE3 = 8'h73;
  localparam logic [7:0] CFG_INDEP = 8'h77;
  localparam logic [7:0] CFG_CHAIN24 = 8'h7c;
  localparam logic [7:0] CFG_SINGLE3_STOP12 = 8'hf3;
  localparam logic [7:0] CFG_INDEP_STOP12 = 8'hf7;
  localparam int TO1_BIT = 0;
  localparam int TO2_BIT = 1;
  localparam int TO3_BIT = 2;
  localparam int FILL_W = 6;
  localparam int STOP_ETU = 12;
  localparam logic [31:0] FIFO_FILL_RESET = 32'h0000_0000;
endpackage

//--- core/contact_uart_timeout_counters.sv
// timeout counter chain, fifo fill level and status registers
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - config 7Ch chains three 8-bit counters into one 24-bit counter
// - 24-bit count starts at first start bit, restarts every start bit
// - reload writes leave running count alone, apply at next start bit
// - 24-bit terminal count sets timeout3_flag and raises interrupt
// - writing 00h to timeout_config stops the counters
// - F3h acts as 73h but counters stop 12 ETU after start bit
// - F7h acts as 77h but counters stop 12 ETU after start bit
// - fifo_fill_status returns fill level in bits 5:0, upper zero
// - fifo_fill_status never raises an interrupt
// - mixed_status is polled only, never raises an interrupt
// - config 73h counts third reload at once, terminal sets flag three
// - config 77h runs three independent counters, first auto-reloads
module contact_uart_timeout_counters
  import tmo_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic etu_tick,
  input wire logic start_bit,
  input wire logic [FILL_W-1:0] fifo_fill_level,
  input wire logic [2:0] mixed_status_in,
  output logic irq
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [7:0] timeout_reload_low, timeout_reload_mid, timeout_reload_high;
  logic [7:0] timeout_config;
  logic [2:0] uart_status_second;
  logic [2:0] irq_mask;
  logic [7:0] cnt1, cnt2, cnt3;
  logic run1, run2, run3;
  logic armed;
  logic [3:0] etu12;
  logic stop_win;

  wire wr_rel_low = wr_en && addr == OFS_RELOAD_LOW;
  wire wr_rel_mid = wr_en && addr == OFS_RELOAD_MID;
  wire wr_rel_high = wr_en && addr == OFS_RELOAD_HIGH;
  wire wr_cfg = wr_en && addr == OFS_CONFIG;
  wire wr_stat = wr_en && addr == OFS_STATUS2;
  wire wr_mask = wr_en && addr == OFS_IRQ_MASK;

  wire mode_chain = timeout_config == CFG_CHAIN24;
  wire mode_single = timeout_config == CFG_SINGLE3 ||
                     timeout_config == CFG_SINGLE3_STOP12;
  wire mode_indep = timeout_config == CFG_INDEP ||
                    timeout_config == CFG_INDEP_STOP12;
  wire mode_stop12 = timeout_config == CFG_SINGLE3_STOP12 ||
                     timeout_config == CFG_INDEP_STOP12;

  function automatic logic at_end(input logic [7:0] v);
    at_end = (v == 8'h01) || (v == 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  wire [23:0] cnt24 = {cnt3, cnt2, cnt1};
  wire tick = etu_tick && !stop_win;
  wire tc24 = mode_chain && run1 && tick && cnt24 <= 24'h00_0001;
  wire tc1 = mode_indep && run1 && tick && at_end(cnt1);
  wire tc2 = mode_indep && run2 && tick && at_end(cnt2);
  wire tc3 = (mode_indep || mode_single) && run3 && tick && at_end(cnt3);
  wire sb_load = start_bit && (armed || mode_chain);
  wire [2:0] events = {tc24 | tc3, tc2, tc1};
  wire any_event = |events;

  // stop window: counters freeze after 12 ETU from first start bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      etu12 <= 4'h0;
      stop_win <= 1'b0;
    end else if (wr_cfg) begin
      etu12 <= 4'h0;
      stop_win <= 1'b0;
    end else if (mode_stop12 && (etu12 != 4'h0 || start_bit && armed)) begin
      if (etu_tick && etu12 == 4'(STOP_ETU))
        stop_win <= 1'b1;
      else if (etu12 == 4'h0)
        etu12 <= 4'h1;
      else if (etu_tick && !stop_win)
        etu12 <= etu12 + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timeout_config <= CFG_STOP;
      armed <= 1'b0;
    end else if (wr_cfg) begin
      timeout_config <= wdata[7:0];
      armed <= 1'b1;
    end else if (start_bit)
      armed <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {cnt3, cnt2, cnt1} <= 24'h00_0000;
      {run3, run2, run1} <= 3'b000;
    end else if (wr_cfg) begin
      {run2, run1} <= 2'b00;
      run3 <= 1'b0;
      // 73h loads counter three at once
      if (wdata[7:0] == CFG_SINGLE3 || wdata[7:0] == CFG_SINGLE3_STOP12 ||
          wdata[7:0] == CFG_INDEP || wdata[7:0] == CFG_INDEP_STOP12) begin
        cnt3 <= timeout_reload_high;
        run3 <= 1'b1;
      end
    end else if (mode_chain) begin
      // reload taken only at start bit
      if (start_bit) begin
        {cnt3, cnt2, cnt1} <= {timeout_reload_high, timeout_reload_mid,
                               timeout_reload_low};
        run1 <= 1'b1;
      end else if (run1 && tick) begin
        if (tc24)
          run1 <= 1'b0;
        else
          {cnt3, cnt2, cnt1} <= cnt24 - 24'h00_0001;
      end
    end else begin
      if (mode_indep && sb_load) begin
        cnt1 <= timeout_reload_low;
        run1 <= 1'b1;
      end else if (tc1)
        cnt1 <= timeout_reload_low;
      else if (mode_indep && run1 && tick)
        cnt1 <= cnt1 - 8'h01;
      if (mode_indep && start_bit) begin
        cnt2 <= timeout_reload_mid;
        run2 <= 1'b1;
      end else if (tc2)
        run2 <= 1'b0;
      else if (mode_indep && run2 && tick)
        cnt2 <= cnt2 - 8'h01;
      if (tc3)
        run3 <= 1'b0;
      else if (run3 && tick)
        cnt3 <= cnt3 - 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timeout_reload_low <= 8'h00;
      timeout_reload_mid <= 8'h00;
      timeout_reload_high <= 8'h00;
      irq_mask <= 3'b000;
    end else begin
      if (wr_rel_low)
        timeout_reload_low <= wdata[7:0];
      if (wr_rel_mid)
        timeout_reload_mid <= wdata[7:0];
      if (wr_rel_high)
        timeout_reload_high <= wdata[7:0];
      if (wr_mask)
        irq_mask <= wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      uart_status_second <= 3'b000;
    else
      uart_status_second <= (uart_status_second &
                             ~(wr_stat ? wdata[2:0] : 3'b000)) | events;
  end

  assign irq = |(uart_status_second & irq_mask);

  // fill read is a plain view, no pop
  wire [31:0] fill_word = {{(32-FILL_W){1'b0}}, fifo_fill_level};
  wire [31:0] next_rdata =
    addr == OFS_RELOAD_LOW ? {24'h00_0000, timeout_reload_low} :
    addr == OFS_RELOAD_MID ? {24'h00_0000, timeout_reload_mid} :
    addr == OFS_RELOAD_HIGH ? {24'h00_0000, timeout_reload_high} :
    addr == OFS_CONFIG ? {24'h00_0000, timeout_config} :
    addr == OFS_STATUS2 ? {29'h0000_0000, uart_status_second} :
    addr == OFS_IRQ_MASK ? {29'h0000_0000, irq_mask} :
    addr == OFS_FIFO_FILL ? fill_word :
    addr == OFS_MIXED ? {29'h0000_0000, mixed_status_in} :
    32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      rdata <= FIFO_FILL_RESET;
    else if (rd_en)
      rdata <= next_rdata;
    else
      rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // register bus and interrupt
  fill_read_a: assert property (@(posedge core_clk) disable iff (rst)
    rd_en && addr == OFS_FIFO_FILL |=>
      rdata == {26'h000_0000, $past(fifo_fill_level)})
    else $error("fill level read wrong");
  mixed_read_a: assert property (@(posedge core_clk) disable iff (rst)
    rd_en && addr == OFS_MIXED |=>
      rdata == {29'h0000_0000, $past(mixed_status_in)})
    else $error("mixed status read wrong");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
    $stable(uart_status_second) && $stable(irq_mask) |-> $stable(irq))
    else $error("irq moved without flag or mask change");
  irq_rise_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(irq) |-> $past(any_event) || $past(wr_mask))
    else $error("irq rose without timeout event");
  flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_stat && wdata[TO3_BIT] && !events[TO3_BIT] |=>
      !uart_status_second[TO3_BIT])
    else $error("timeout flag not cleared");
  // chain mode, stop window outside stop modes, config stop
  chain_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    tc24 |=> uart_status_second[TO3_BIT])
    else $error("24-bit terminal count lost");
  chain_load_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_chain && start_bit && !wr_cfg |=> run1 &&
      cnt24 == {$past(timeout_reload_high), $past(timeout_reload_mid),
                $past(timeout_reload_low)})
    else $error("chain not loaded at start bit");
  reload_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_chain && run1 && !start_bit && !etu_tick && !wr_cfg |=>
      cnt24 == $past(cnt24))
    else $error("running count disturbed");
  reload_write_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_chain && run1 && !start_bit && !etu_tick &&
      (wr_rel_low || wr_rel_mid || wr_rel_high) |=> cnt24 == $past(cnt24))
    else $error("reload write moved running count");
  chain_step_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_chain && run1 && tick && !tc24 && !start_bit && !wr_cfg |=>
      cnt24 == $past(cnt24) - 24'h00_0001)
    else $error("chain count step wrong");
  chain_end_a: assert property (@(posedge core_clk) disable iff (rst)
    tc24 && !start_bit && !wr_cfg |=> !run1)
    else $error("chain still running after terminal count");
  win_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !mode_stop12 |-> !stop_win)
    else $error("counters frozen outside stop modes");
  stop_cfg_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_cfg && wdata[7:0] == CFG_STOP |=> !run1 && !run2 && !run3)
    else $error("counters not stopped");
  // single and independent modes
  single_go_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_cfg && wdata[7:0] == CFG_SINGLE3 |=>
      run3 && cnt3 == $past(timeout_reload_high))
    else $error("third counter not started");
  single_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    tc3 |=> uart_status_second[TO3_BIT])
    else $error("third counter flag lost");
  auto_reload_a: assert property (@(posedge core_clk) disable iff (rst)
    tc1 && !start_bit && !wr_cfg |=> cnt1 == $past(timeout_reload_low) && run1)
    else $error("first counter no auto-reload");
  indep_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    tc1 |=> uart_status_second[TO1_BIT])
    else $error("first counter flag lost");
  mid_load_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_indep && start_bit && !wr_cfg |=>
      run2 && cnt2 == $past(timeout_reload_mid))
    else $error("second counter not loaded");
  first_only_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_indep && start_bit && !armed && !etu_tick && !wr_cfg |=>
      cnt1 == $past(cnt1))
    else $error("first counter reloaded by late start bit");
  // stop window
  win_freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    stop_win && !wr_cfg && !start_bit |=> cnt3 == $past(cnt3))
    else $error("counter moved after stop window");
  win_set_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_stop12 && etu_tick && etu12 == 4'(STOP_ETU) && !wr_cfg |=> stop_win)
    else $error("stop window not closed after twelve etu");

endmodule
`default_nettype wire

//--- tb/card_io_model.sv
// card-side model: start bits on the i/o line and etu pacing
`timescale 1ns/10ps
`default_nettype none
module card_io_model (
  input wire logic core_clk,
  output logic start_bit,
  output logic etu_tick
);
  initial begin
    start_bit = 1'b0;
    etu_tick = 1'b0;
  end
  // one start bit, always apart from any etu pulse
  task automatic send_start();
    start_bit <= 1'b1;
    @(posedge core_clk);
    start_bit <= 1'b0;
    @(posedge core_clk);
  endtask
  // gap above one models a slow card between etu pulses
  task automatic run_etu(input int n, input int gap);
    repeat (n) begin
      etu_tick <= 1'b1;
      @(posedge core_clk);
      etu_tick <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/contact_uart_timeout_counters_test.sv
// self-checking bench for the timeout counter block
`timescale 1ns/10ps
`default_nettype none
module contact_uart_timeout_counters_test
  import tmo_pkg::*;
;
  logic rst, wr_en, rd_en, start_bit, etu_tick, irq;
  logic core_clk = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [FILL_W-1:0] fifo_fill_level;
  logic [2:0] mixed_status_in;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int n_compared = 0;
  contact_uart_timeout_counters u_dut (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .etu_tick(etu_tick), .start_bit(start_bit),
    .fifo_fill_level(fifo_fill_level), .mixed_status_in(mixed_status_in),
    .irq(irq));
  card_io_model u_card (.core_clk(core_clk), .start_bit(start_bit),
    .etu_tick(etu_tick));
  always #20 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a clock edge passes after each strobe so tasks may follow each other
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic tk(input int n);
    u_card.run_etu(n, 1 + $urandom_range(2));
  endtask
  task automatic st(input logic [31:0] e);
    rd(OFS_STATUS2, e);
    wr(OFS_STATUS2, 32'h7);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] rdata expected none seen %h", rdata);
      end else
        chk("rdata", exp_q.pop_front(), rdata);
    end
    rd_q <= rd_en;
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    num_errors++;
    $display("[ERR] watchdog expected end seen hang");
    conclude();
  end
  initial begin
    rst = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fifo_fill_level = '0;
    mixed_status_in = 3'h0;
    void'($urandom(91142));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_FIFO_FILL, FIFO_FILL_RESET);
    wr(OFS_IRQ_MASK, 32'h7);
    repeat (4) begin
      fifo_fill_level <= FILL_W'($urandom);
      mixed_status_in <= 3'($urandom);
      @(posedge core_clk);
      rd(OFS_FIFO_FILL, 32'(fifo_fill_level));
      rd(OFS_FIFO_FILL, 32'(fifo_fill_level));
      rd(OFS_MIXED, 32'(mixed_status_in));
      chk("irq", 32'h0, 32'(irq));
    end
    rd(8'h40, 32'h0);
    wr(OFS_RELOAD_LOW, 32'h2);
    wr(OFS_RELOAD_MID, 32'h1);
    wr(OFS_RELOAD_HIGH, 32'h0);
    wr(OFS_CONFIG, 32'(CFG_CHAIN24));
    tk(300);
    rd(OFS_STATUS2, 32'h0);
    u_card.send_start();
    tk(1);
    wr(OFS_RELOAD_LOW, 32'h5);
    rd(OFS_RELOAD_LOW, 32'h5);
    tk(256);
    rd(OFS_STATUS2, 32'h0);
    tk(1);
    rd(OFS_STATUS2, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h3);
    chk("irq", 32'h0, 32'(irq));
    rd(OFS_IRQ_MASK, 32'h3);
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_STATUS2, 32'h7);
    chk("irq", 32'h0, 32'(irq));
    u_card.send_start();
    tk(100);
    u_card.send_start();
    tk(260);
    rd(OFS_STATUS2, 32'h0);
    tk(1);
    st(32'h4);
    u_card.send_start();
    tk(100);
    wr(OFS_CONFIG, 32'(CFG_STOP));
    rd(OFS_CONFIG, 32'(CFG_STOP));
    tk(200);
    st(32'h0);
    wr(OFS_RELOAD_HIGH, 32'h3);
    wr(OFS_CONFIG, 32'(CFG_SINGLE3));
    tk(2);
    rd(OFS_STATUS2, 32'h0);
    tk(1);
    st(32'h4);
    wr(OFS_RELOAD_HIGH, 32'h14);
    wr(OFS_CONFIG, 32'(CFG_SINGLE3_STOP12));
    u_card.send_start();
    tk(30);
    st(32'h0);
    wr(OFS_RELOAD_LOW, 32'h2);
    wr(OFS_RELOAD_MID, 32'hff);
    wr(OFS_RELOAD_HIGH, 32'hff);
    wr(OFS_CONFIG, 32'(CFG_INDEP));
    u_card.send_start();
    tk(2);
    st(32'h1);
    tk(1);
    u_card.send_start();
    tk(1);
    st(32'h1);
    wr(OFS_CONFIG, 32'(CFG_INDEP_STOP12));
    u_card.send_start();
    tk(12);
    wr(OFS_STATUS2, 32'h7);
    tk(4);
    st(32'h0);
    conclude();
  end
endmodule
`default_nettype wire
